/* include/ccd_defs.vh */
// Constants for the class code decompressor
// Assumes inclusion by bare name from the logic files
`ifndef CCD_DEFS_VH
`define CCD_DEFS_VH
`define CCD_CLASS_W 4
`define CCD_NUM_CLASS 16
`define CCD_MIN_LEN 6
`define CCD_MAX_LEN 36
`define CCD_PTR_MIN 2
`define CCD_PTR_MAX 9
`define CCD_RAM_AW 9
`define CCD_TBL_ALIGN 3
`define CCD_BRANCH_CODE 4'hd
`define CCD_AA_POS 1
// Class configuration word layout
`define CCD_CFG_W 24
`define CCD_CFG_P1LEN_LSB 0
`define CCD_CFG_P2LEN_LSB 4
`define CCD_CFG_MODE_LSB 8
`define CCD_CFG_BASE1_LSB 10
`define CCD_CFG_BASE2_LSB 16
`define CCD_CFG_BYP_LSB 22
// Mode encodings
`define CCD_MODE_BYP32 2'h0
`define CCD_MODE_CMP32 2'h1
`define CCD_MODE_CMPBYP 2'h2
`define CCD_MODE_CMP2 2'h3
// Bypass lengths
`define CCD_BYP_NONE 3'h0
`define CCD_BYP_10 3'h1
`define CCD_BYP_15 3'h2
`define CCD_BYP_16 3'h3
`define CCD_BYP_32 3'h4
`endif

/* logic/ccd_bit_window.v */
// Shift extractor for a field of the code stream
// Assumes the stream window is given with its first bit at index 0
`timescale 1ns/1ps
`default_nettype none
module ccd_bit_window (
  input wire [63:0] stream,
  input wire [5:0] offset,
  output wire [31:0] field
);
  // ------------------------------------------------------------
  // Stream bit k of the field lands at field bit k
  // ------------------------------------------------------------
  wire [63:0] shifted;
  assign shifted = stream >> offset;
  assign field = shifted[31:0];
endmodule
`default_nettype wire

/* logic/ccd_decoder.v */
// Class code decompressor: parses compressed stream into 32-bit instructions
// Assumes stream words arrive with valid/ready; first stream bit is word bit 0
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defs.vh"
module ccd_decoder (
  input wire sys_clk,
  input wire sys_rst,
  input wire [31:0] fetch_data,
  input wire fetch_valid,
  output wire fetch_ready,
  input wire [4:0] start_bit,
  input wire start_load,
  input wire cfg_we,
  input wire [3:0] cfg_class,
  input wire [23:0] cfg_data,
  input wire ram_we,
  input wire ram_sel,
  input wire [8:0] ram_waddr,
  input wire [15:0] ram_wdata,
  output reg [31:0] insn_data_r,
  output reg insn_valid_r,
  input wire insn_ready,
  output reg [5:0] insn_len_r
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [2:0] ST_PARSE = 3'b001;
  localparam [2:0] ST_LOOK = 3'b010;
  localparam [2:0] ST_OUT = 3'b100;

  reg [2:0] state_r, state_nxt;
  // Room for 34 buffered bits plus one more word, so no fill level can stall
  reg [71:0] buf_r, buf_nxt;
  reg [6:0] fill_r, fill_nxt;
  reg [23:0] class_configuration_register [0:15];
  reg [31:0] byp_r;
  reg [1:0] mode_r;
  reg [31:0] insn_nxt;
  reg [15:0] voc_l_r;
  reg [15:0] voc_r_r;

  // ------------------------------------------------------------
  // Class configuration registers
  // ------------------------------------------------------------
  integer i;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      for (i = 0; i < `CCD_NUM_CLASS; i = i + 1) begin
        class_configuration_register[i] <= 24'h000000;
      end
    end else if (cfg_we) begin
      class_configuration_register[cfg_class] <= cfg_data;
    end
  end

  // ------------------------------------------------------------
  // Field parse
  // ------------------------------------------------------------
  wire [3:0] cls;
  assign cls = buf_r[3:0];
  wire [23:0] cfg;
  assign cfg = class_configuration_register[cls];
  wire [3:0] p1len;
  wire [3:0] right_pointer_length_field;
  wire [1:0] mode;
  wire [5:0] base1;
  wire [5:0] base2;
  wire [2:0] bypsel;
  assign p1len = cfg[`CCD_CFG_P1LEN_LSB +: 4];
  assign right_pointer_length_field = cfg[`CCD_CFG_P2LEN_LSB +: 4];
  assign mode = cfg[`CCD_CFG_MODE_LSB +: 2];
  assign base1 = cfg[`CCD_CFG_BASE1_LSB +: 6];
  assign base2 = cfg[`CCD_CFG_BASE2_LSB +: 6];
  // Bypass length follows the partition; a full bypass is always 32 bits
  assign bypsel = (mode == `CCD_MODE_BYP32) ? `CCD_BYP_32 :
    (mode == `CCD_MODE_CMPBYP) ? {1'b0, cfg[`CCD_CFG_BYP_LSB +: 2]} : `CCD_BYP_NONE;

  wire branch_fmt;
  assign branch_fmt = (right_pointer_length_field == `CCD_BRANCH_CODE) &&
    (mode == `CCD_MODE_CMPBYP);
  wire [3:0] p2len;
  assign p2len = (mode == `CCD_MODE_CMP2 && !branch_fmt) ? right_pointer_length_field : 4'h0;
  wire [3:0] p1eff;
  assign p1eff = (mode == `CCD_MODE_BYP32) ? 4'h0 : p1len;

  reg [5:0] byplen;
  always @* begin
    case (bypsel)
      `CCD_BYP_10: byplen = 6'd10;
      `CCD_BYP_15: byplen = 6'd15;
      `CCD_BYP_16: byplen = 6'd16;
      `CCD_BYP_32: byplen = 6'd32;
      default: byplen = 6'd0;
    endcase
    if (branch_fmt) begin
      byplen = 6'd15;
    end
  end

  wire [5:0] off_p1;
  wire [5:0] off_p2;
  wire [5:0] off_byp;
  assign off_p1 = 6'd4;
  assign off_p2 = off_p1 + {2'b00, p1eff};
  assign off_byp = off_p2 + {2'b00, p2len};
  wire [5:0] raw_len;
  assign raw_len = off_byp + byplen;
  // Odd totals round to even
  wire [5:0] ins_len;
  assign ins_len = raw_len + {5'd0, raw_len[0]};

  wire [31:0] f_p1;
  wire [31:0] f_p2;
  wire [31:0] f_byp;
  ccd_bit_window u_w1 (.stream(buf_r[63:0]), .offset(off_p1), .field(f_p1));
  ccd_bit_window u_w2 (.stream(buf_r[63:0]), .offset(off_p2), .field(f_p2));
  ccd_bit_window u_wb (.stream(buf_r[63:0]), .offset(off_byp), .field(f_byp));

  // First stream bit becomes pointer LSB
  wire [8:0] ptr1;
  wire [8:0] ptr2;
  genvar g;
  generate
    for (g = 0; g < `CCD_PTR_MAX; g = g + 1) begin : g_ptr
      assign ptr1[g] = (g < p1eff) ? f_p1[g] : 1'b0;
      assign ptr2[g] = (g < p2len) ? f_p2[g] : 1'b0;
    end
  endgenerate

  wire [8:0] addr1;
  wire [8:0] addr2;
  assign addr1 = {base1, 3'b000} + ptr1;
  // Full 32-bit compression reads the same pointer from both memories
  assign addr2 = (mode == `CCD_MODE_CMP32) ? addr1 : ({base2, 3'b000} + ptr2);

  // ------------------------------------------------------------
  // Vocabulary memories, left and right halves
  // ------------------------------------------------------------
  wire [15:0] voc_l;
  wire [15:0] voc_r;
  ccd_vocab_ram u_vocabulary_table_ram_l (
    .sys_clk(sys_clk),
    .we(ram_we && !ram_sel),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(addr1),
    .rdata(voc_l)
  );
  ccd_vocab_ram u_vocabulary_table_ram_r (
    .sys_clk(sys_clk),
    .we(ram_we && ram_sel),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(addr2),
    .rdata(voc_r)
  );

  // ------------------------------------------------------------
  // Bypass expansion
  // ------------------------------------------------------------
  reg [31:0] byp_exp;
  always @* begin
    byp_exp = 32'h00000000;
    if (branch_fmt) begin
      byp_exp[15:0] = {f_byp[14:1], 1'b0, f_byp[0]};
    end else begin
      case (bypsel)
        `CCD_BYP_10: byp_exp[15:0] = {6'h00, f_byp[9:0]};
        `CCD_BYP_15: byp_exp[15:0] = {1'b0, f_byp[14:0]};
        `CCD_BYP_16: byp_exp[15:0] = f_byp[15:0];
        `CCD_BYP_32: byp_exp = f_byp;
        default: byp_exp = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Instruction assembly
  // ------------------------------------------------------------
  always @* begin
    case (mode_r)
      `CCD_MODE_BYP32: insn_nxt = byp_r;
      `CCD_MODE_CMP32: insn_nxt = {voc_l_r, voc_r_r};
      `CCD_MODE_CMPBYP: insn_nxt = {voc_l_r, byp_r[15:0]};
      `CCD_MODE_CMP2: insn_nxt = {voc_l_r, voc_r_r};
      default: insn_nxt = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------
  // Stream buffer and control
  // ------------------------------------------------------------
  wire can_fill;
  // Accepting at 34 closes the gap below the 36-bit parse threshold
  assign can_fill = (fill_r <= 7'd34) && (state_r == ST_PARSE);
  assign fetch_ready = can_fill;
  wire have_insn;
  assign have_insn = (fill_r >= {1'b0, ins_len}) && (fill_r >= 7'd4);

  always @* begin
    state_nxt = state_r;
    buf_nxt = buf_r;
    fill_nxt = fill_r;
    case (state_r)
      ST_PARSE: begin
        if (have_insn && fill_r >= 7'd36) begin
          buf_nxt = buf_r >> ins_len;
          fill_nxt = fill_r - {1'b0, ins_len};
          state_nxt = ST_LOOK;
        end else if (fetch_valid && can_fill) begin
          if (start_load) begin
            // Skip to an even bit inside the first word
            buf_nxt = {40'h0000000000, fetch_data} >> {start_bit[4:1], 1'b0};
            fill_nxt = 7'd32 - {2'b00, start_bit[4:1], 1'b0};
          end else begin
            buf_nxt = buf_r | ({40'h0000000000, fetch_data} << fill_r);
            fill_nxt = fill_r + 7'd32;
          end
        end
      end
      ST_LOOK: state_nxt = ST_OUT;
      // One idle cycle after each accept keeps valid low for a cycle
      ST_OUT: begin
        if (!insn_valid_r) begin
          state_nxt = ST_PARSE;
        end
      end
      default: state_nxt = ST_PARSE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_PARSE;
      buf_r <= 72'h000000000000000000;
      voc_l_r <= 16'h0000;
      voc_r_r <= 16'h0000;
      fill_r <= 7'h00;
      byp_r <= 32'h00000000;
      mode_r <= 2'h0;
      insn_data_r <= 32'h00000000;
      insn_valid_r <= 1'b0;
      insn_len_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      buf_r <= buf_nxt;
      fill_r <= fill_nxt;
      if (insn_valid_r && insn_ready) begin
        insn_valid_r <= 1'b0;
      end
      // Memory output shows this instruction only during lookup
      if (state_r == ST_LOOK) begin
        voc_l_r <= voc_l;
        voc_r_r <= voc_r;
      end
      if (state_r == ST_PARSE && state_nxt == ST_LOOK) begin
        byp_r <= byp_exp;
        mode_r <= mode;
        insn_len_r <= ins_len;
      end
      if (state_r == ST_OUT && !insn_valid_r) begin
        insn_data_r <= insn_nxt;
        insn_valid_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* logic/ccd_vocab_ram.v */
// Vocabulary table memory, one read port, one load port
// Assumes load writes come from system setup before decoding
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defs.vh"
module ccd_vocab_ram (
  input wire sys_clk,
  input wire we,
  input wire [8:0] waddr,
  input wire [15:0] wdata,
  input wire [8:0] raddr,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:511];
  always @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* tb/ccd_decoder_props.sv */
// Checker for the class code decompressor top ports
// Assumes binding onto ccd_decoder, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module ccd_decoder_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic fetch_valid,
  input wire logic fetch_ready,
  input wire logic start_load,
  input wire logic insn_ready,
  input wire logic insn_valid_r,
  input wire logic [31:0] insn_data_r,
  input wire logic [5:0] insn_len_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_valid_hold: assert property (insn_valid_r && !insn_ready |=> insn_valid_r)
    else $error("valid dropped before accept");
  a_data_hold: assert property (insn_valid_r && !insn_ready |=>
    $stable(insn_data_r) && $stable(insn_len_r))
    else $error("output changed before accept");
  a_valid_drop: assert property (insn_valid_r && insn_ready |=> !insn_valid_r)
    else $error("valid not cleared after accept");
  a_len_even: assert property (insn_valid_r |-> insn_len_r[0] == 1'b0)
    else $error("odd length");
  a_len_range: assert property (insn_valid_r |-> insn_len_r >= 6'h06 && insn_len_r <= 6'h24)
    else $error("length out of range");
  a_no_early: assert property ($fell(sys_rst) |-> !insn_valid_r [*3])
    else $error("output too early after reset");
  a_answer_bound: assert property ((fetch_valid && fetch_ready && start_load) ##1
    (fetch_valid && fetch_ready) |-> ##[1:8] insn_valid_r)
    else $error("no instruction after fill");
  a_refuse_full: assert property ((fetch_valid && fetch_ready && start_load) ##1
    (fetch_valid && fetch_ready) |=> !fetch_ready)
    else $error("ready with full buffer");
endmodule
bind ccd_decoder ccd_decoder_props i_ccd_decoder_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .start_load(start_load),
  .insn_ready(insn_ready), .insn_valid_r(insn_valid_r), .insn_data_r(insn_data_r),
  .insn_len_r(insn_len_r));
`default_nettype wire

/* tb/ccd_fetch_model.sv */
// Fetch unit model: offers four code words with valid/ready
// Assumes the image is stable while go is high
`timescale 1ns/1ps
`default_nettype none
module ccd_fetch_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [127:0] image,
  input wire logic fetch_ready,
  output logic [31:0] fetch_data,
  output logic fetch_valid,
  output logic start_load,
  output logic [4:0] start_bit
);
  logic took_r = 1'b0;
  logic [31:0] data_q = 32'h0;
  logic valid_q = 1'b0;
  int idx;
  assign fetch_data = data_q;
  assign fetch_valid = valid_q;
  assign start_load = valid_q && idx == 0;
  assign start_bit = 5'h06;
  always @(posedge sys_clk) took_r <= valid_q && fetch_ready;
  // Word held until taken; released data is inverted
  always @(negedge sys_clk) begin
    if (!go) begin
      idx = 0;
      if (valid_q)
        data_q = ~data_q;
      valid_q = 1'b0;
    end else begin
      if (took_r)
        idx = idx + 1;
      if (idx < 4) begin
        data_q = image[idx*32 +: 32];
        valid_q = 1'b1;
      end else if (valid_q) begin
        data_q = ~data_q;
        valid_q = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench for the class code decompressor
// Assumes the fetch model feeds the stream; bench drives at falling edge
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defs.vh"
module tb_top;
  logic sys_clk = 0, sys_rst = 1, cfg_we = 0, ram_we = 0, ram_sel = 0, insn_ready = 0, go = 0;
  logic [3:0] cfg_class = 0;
  logic [23:0] cfg_data = 0;
  logic [8:0] ram_waddr = 0;
  logic [15:0] ram_wdata = 0;
  logic [127:0] image = 0;
  logic [14:0] byp = 15'h2abc;
  wire fetch_ready, fetch_valid, start_load, insn_valid_r;
  wire [31:0] fetch_data, insn_data_r;
  wire [4:0] start_bit;
  wire [5:0] insn_len_r;
  int mismatches = 0, cmp_count = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  ccd_decoder i_ccd_decoder (.sys_clk(sys_clk), .sys_rst(sys_rst), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .start_bit(start_bit),
    .start_load(start_load), .cfg_we(cfg_we), .cfg_class(cfg_class), .cfg_data(cfg_data),
    .ram_we(ram_we), .ram_sel(ram_sel), .ram_waddr(ram_waddr), .ram_wdata(ram_wdata),
    .insn_data_r(insn_data_r), .insn_valid_r(insn_valid_r), .insn_ready(insn_ready),
    .insn_len_r(insn_len_r));
  ccd_fetch_model i_ccd_fetch_model (.sys_clk(sys_clk), .go(go), .image(image),
    .fetch_ready(fetch_ready), .fetch_data(fetch_data), .fetch_valid(fetch_valid),
    .start_load(start_load), .start_bit(start_bit));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task chk(input logic [37:0] got, input logic [37:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task load_tables;
    for (int a = 0; a < 64; a++) begin
      ram_we = 1;
      ram_sel = a[5];
      ram_waddr = {4'h0, a[4:0]};
      ram_wdata = (a[5] ? 16'h2000 : 16'h1000) + {11'h0, a[4:0]};
      @(negedge sys_clk);
    end
    ram_we = 0;
    cfg_we = 1;
    cfg_class = 4'h3;
    cfg_data = {2'h0, 6'h02, 6'h01, 2'h3, 4'h9, 4'h2};
    @(negedge sys_clk);
    cfg_class = 4'h0;
    @(negedge sys_clk);
    cfg_class = 4'hd;
    cfg_data = {2'h2, 6'h00, 6'h03, 2'h2, 4'hd, 4'h3};
    @(negedge sys_clk);
    cfg_we = 0;
  endtask
  task get_insn(input logic [37:0] exp);
    int n;
    n = 0;
    while (insn_valid_r !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      end_of_test;
    end
    chk({insn_len_r, insn_data_r}, exp);
    insn_ready = 1;
    @(negedge sys_clk);
    insn_ready = 0;
  endtask
  // Two halves at offset 6, then a branch bypass right behind it
  task run_stream;
    image[6 +: 4] = 4'h3;
    image[10 +: 2] = 2'h2;
    image[12 +: 9] = 9'h005;
    image[22 +: 4] = 4'hd;
    image[26 +: 3] = 3'h5;
    image[29 +: 15] = byp;
    go = 1;
    get_insn({6'h10, 16'h100a, 16'h2015});
    get_insn({6'h16, 16'h101d, byp[14:1], 1'b0, byp[0]});
    go = 0;
  endtask
  // Full compression, then a full bypass from a class left at its reset value
  task run_wide;
    cfg_we = 1;
    cfg_class = 4'h5;
    cfg_data = {2'h0, 6'h00, 6'h02, 2'h1, 4'h0, 4'h5};
    @(negedge sys_clk);
    cfg_we = 0;
    image = 0;
    image[6 +: 4] = 4'h5;
    image[10 +: 5] = 5'h0b;
    image[20 +: 32] = 32'h5a3c96e1;
    go = 1;
    get_insn({6'h0a, 16'h101b, 16'h201b});
    get_insn({6'h24, 32'h5a3c96e1});
    go = 0;
  endtask
  task reset_for(input int cycles);
    sys_rst = 1;
    go = 0;
    insn_ready = 0;
    repeat (cycles) @(negedge sys_clk);
    sys_rst = 0;
    chk({insn_len_r, insn_data_r}, 38'h0);
    chk({37'h0, fetch_ready}, 38'h1);
  endtask
  initial begin
    reset_for(10);
    load_tables;
    run_stream;
    reset_for(2);
    run_wide;
    end_of_test;
  end
endmodule
`default_nettype wire
